// >>> adc_ctrl_params.svh
// Register map, field positions, reset values and timing figures of the control block
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
`define REG_IRQ_ENABLE 8'h60
`define REG_IRQ_CFG 8'h62
`define REG_PWR_REQ 8'h70
`define REG_PROC_CTRL 8'h71
`define REG_PWR_STAT 8'h72
`define REG_RATE_CLASS 8'h73
`define IRQ_CFG_RST 8'h10
`define PWR_REQ_RST 8'h70
`define PROC_CTRL_RST 8'h10
`define RD_UNMAPPED 8'h00
`define SENSE_HI 5
`define SENSE_LO 4
`define WIDTH_HI 1
`define WIDTH_LO 0
`define SENSE_LOW 2'h0
`define SENSE_HIGH 2'h1
`define SENSE_OPEN_DRAIN 2'h2
`define WIDTH_LEVEL 2'h3
`define PWR_ANALOG_BIT 2
`define PWR_SLEEP_BIT 1
`define PWR_HOLD_BIT 0
`define PROC_TWO_CH_BIT 7
`define PROC_FLT_BIT 5
`define PROC_HPF_BIT 4
`define PROC_MUTE_C2R 3
`define PROC_MUTE_C2L 2
`define PROC_MUTE_C1R 1
`define PROC_MUTE_C1L 0
`define CLK_PERIOD_PS 5000
`define IRQ_UNIT_MS 1
`define IRQ_UNIT_CYC ((`IRQ_UNIT_MS * 1000000000) / `CLK_PERIOD_PS)
`define FADE_CYC 8
`endif

// >>> adc_ctrl_pkg.sv
// Types of the power-state, interrupt-pin and register control block
package adc_ctrl_pkg;
    typedef enum logic [3:0] {
        PS_POWER_DOWN = 4'h0,
        PS_WAIT_CLOCK = 4'h1,
        PS_RELEASE = 4'h2,
        PS_STANDBY = 4'h3,
        PS_FADE_IN = 4'h4,
        PS_FADE_OUT = 4'h5,
        PS_SLEEP = 4'h9,
        PS_RUN = 4'hf
    } psm_e;

    typedef struct packed {
        logic [7:0] irq_cfg;
        logic [7:0] pwr_req;
        logic [7:0] proc_ctrl;
        psm_e psm;
        logic [7:0] fade_cnt;
        logic [2:0] rate;
        logic [19:0] irq_cnt;
        logic irq_active;
        logic irq_out;
        logic irq_oe;
        logic flags_clear;
        logic two_ch;
        logic detect_en;
        logic analog_off;
        logic [7:0] rdata;
    } ctrl_s;
endpackage : adc_ctrl_pkg

// >>> adc_power_state_irq_ctrl.sv
// Control and status registers, power-state sequencer and interrupt pin driver
// Summary of operation
// - Interrupt pin sense field: 00 low, 01 high (reset), 10 open-drain low.
// - Interrupt pulse width field: 00 1 ms (reset), 01 2 ms, 10 3 ms.
// - Width code 11 holds interrupt asserted as level until acknowledged.
// - Power bit 2 set puts analog section into power-down.
// - Power bit 1 set enters sleep; sleep starts audio-content detection.
// - Power bit 0 selects run (0) or digital standby (1).
// - Processing bit 7 selects four-channel (0) or two-channel (1) processing.
// - Processing bit 5 selects normal (0) or short-latency (1) decimation filter.
// - Processing bit 4 enables high-pass filter; enabled after reset.
// - Processing bits 3..0 mute ch2 right, ch2 left, ch1 right, ch1 left.
// - Read-only four-bit field reports current power-state machine code.
// - Read-only three-bit field reports detected sampling-rate class.
// - Writing zero to interrupt enable register clears latched interrupt flags.
`include "adc_ctrl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_power_state_irq_ctrl #(
    parameter int IRQ_UNIT_CYCLES = `IRQ_UNIT_CYC,
    parameter int FADE_CYCLES = `FADE_CYC
) (
    input wire logic clk, // 200 MHz clock
    input wire logic nrst, // Async reset, active low
    input wire logic [7:0] reg_addr, // Control port register address
    input wire logic [7:0] reg_wdata, // Control port write data
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic reg_rd, // Read strobe, one cycle
    output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
    input wire logic irq_event, // Interrupt flag raised, one-cycle pulse
    input wire logic clk_stable, // Audio clocks detected stable
    input wire logic [2:0] rate_class_in, // Rate class from frame clock detector
    output logic irq_out, // Interrupt pin output level
    output logic irq_oe, // Interrupt pin output enable
    output logic irq_flags_clear, // Pulse: clear latched interrupt flags
    output logic analog_powered_down, // Analog section held powered down
    output logic audio_detect_en, // Audio-content detector running
    output logic two_channel_processing, // Two-channel processing mode
    output logic decimator_response_sel, // Short-latency decimation filter
    output logic highpass_on, // High-pass filter enabled
    output logic silence_second_right, // Mute channel 2 right
    output logic silence_second_left, // Mute channel 2 left
    output logic silence_first_right, // Mute channel 1 right
    output logic silence_first_left, // Mute channel 1 left
    output logic [3:0] power_state, // Current power-state code
    output logic [2:0] detected_rate_class // Detected sampling-rate class
);
    localparam adc_ctrl_pkg::ctrl_s RST_STATE = '{
        irq_cfg: `IRQ_CFG_RST,
        pwr_req: `PWR_REQ_RST,
        proc_ctrl: `PROC_CTRL_RST,
        psm: adc_ctrl_pkg::PS_POWER_DOWN,
        irq_oe: 1'b1,
        analog_off: 1'b1,
        default: '0
    };

    adc_ctrl_pkg::ctrl_s r;
    adc_ctrl_pkg::ctrl_s n;
    logic ack_write;
    logic [1:0] sense;
    logic [1:0] width;

    assign ack_write = reg_wr && (reg_addr == `REG_IRQ_ENABLE) && (reg_wdata == 8'h00);
    assign sense = r.irq_cfg[`SENSE_HI:`SENSE_LO];
    assign width = r.irq_cfg[`WIDTH_HI:`WIDTH_LO];

    always_comb begin
        n = r;
        n.flags_clear = ack_write;
        if (reg_wr) begin
            case (reg_addr)
                `REG_IRQ_CFG: n.irq_cfg = reg_wdata;
                // Reserved bits kept as written; host restores the 01110 pattern
                `REG_PWR_REQ: n.pwr_req = reg_wdata;
                `REG_PROC_CTRL: n.proc_ctrl = reg_wdata;
                default: ; // Status registers ignore writes
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `REG_IRQ_CFG: n.rdata = r.irq_cfg;
                `REG_PWR_REQ: n.rdata = r.pwr_req;
                `REG_PROC_CTRL: n.rdata = r.proc_ctrl;
                `REG_PWR_STAT: n.rdata = {4'h0, r.psm};
                `REG_RATE_CLASS: n.rdata = {5'h00, r.rate};
                default: n.rdata = `RD_UNMAPPED;
            endcase
        end
        n.rate = rate_class_in;

        // Power-state sequencer
        case (r.psm)
            adc_ctrl_pkg::PS_POWER_DOWN: begin
                if (!r.pwr_req[`PWR_ANALOG_BIT]) begin
                    n.psm = adc_ctrl_pkg::PS_WAIT_CLOCK;
                end
            end
            adc_ctrl_pkg::PS_WAIT_CLOCK: begin
                if (r.pwr_req[`PWR_ANALOG_BIT]) begin
                    n.psm = adc_ctrl_pkg::PS_POWER_DOWN;
                end else if (clk_stable) begin
                    n.psm = adc_ctrl_pkg::PS_RELEASE;
                end
            end
            adc_ctrl_pkg::PS_RELEASE: n.psm = adc_ctrl_pkg::PS_STANDBY;
            adc_ctrl_pkg::PS_STANDBY: begin
                if (r.pwr_req[`PWR_ANALOG_BIT]) begin
                    n.psm = adc_ctrl_pkg::PS_POWER_DOWN;
                end else if (r.pwr_req[`PWR_SLEEP_BIT]) begin
                    n.psm = adc_ctrl_pkg::PS_SLEEP;
                end else if (!r.pwr_req[`PWR_HOLD_BIT]) begin
                    n.psm = adc_ctrl_pkg::PS_FADE_IN;
                    n.fade_cnt = 8'(FADE_CYCLES - 1);
                end
            end
            adc_ctrl_pkg::PS_FADE_IN: begin
                if (r.fade_cnt == 8'h00) begin
                    n.psm = adc_ctrl_pkg::PS_RUN;
                end else begin
                    n.fade_cnt = r.fade_cnt - 8'h01;
                end
            end
            adc_ctrl_pkg::PS_RUN: begin
                if (r.pwr_req[`PWR_ANALOG_BIT:`PWR_HOLD_BIT] != 3'h0) begin
                    n.psm = adc_ctrl_pkg::PS_FADE_OUT;
                    n.fade_cnt = 8'(FADE_CYCLES - 1);
                end
            end
            adc_ctrl_pkg::PS_FADE_OUT: begin
                if (r.fade_cnt == 8'h00) begin
                    n.psm = adc_ctrl_pkg::PS_STANDBY;
                end else begin
                    n.fade_cnt = r.fade_cnt - 8'h01;
                end
            end
            adc_ctrl_pkg::PS_SLEEP: begin
                if (!r.pwr_req[`PWR_SLEEP_BIT] || r.pwr_req[`PWR_ANALOG_BIT]) begin
                    n.psm = adc_ctrl_pkg::PS_STANDBY;
                end
            end
            default: n.psm = adc_ctrl_pkg::PS_POWER_DOWN;
        endcase
        n.analog_off = (n.psm == adc_ctrl_pkg::PS_POWER_DOWN);
        n.detect_en = (n.psm == adc_ctrl_pkg::PS_SLEEP);
        // Channel count only follows the register outside run, so a late write cannot glitch
        if (n.psm != adc_ctrl_pkg::PS_RUN) begin
            n.two_ch = n.proc_ctrl[`PROC_TWO_CH_BIT];
        end

        // Interrupt pulse timer; a new event wins over an acknowledge
        if (irq_event) begin
            n.irq_active = 1'b1;
            n.irq_cnt = 20'(IRQ_UNIT_CYCLES * (int'(width) + 1) - 1);
        end else if (r.irq_active) begin
            if (width == `WIDTH_LEVEL) begin
                n.irq_active = !ack_write;
            end else if (r.irq_cnt == 20'h00000) begin
                n.irq_active = 1'b0;
            end else begin
                n.irq_cnt = r.irq_cnt - 20'h00001;
            end
        end
        case (sense)
            `SENSE_LOW: begin
                n.irq_out = !n.irq_active;
                n.irq_oe = 1'b1;
            end
            `SENSE_OPEN_DRAIN: begin
                n.irq_out = 1'b0;
                n.irq_oe = n.irq_active;
            end
            // Reserved code behaves as active high
            default: begin
                n.irq_out = n.irq_active;
                n.irq_oe = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= RST_STATE;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign irq_out = r.irq_out;
    assign irq_oe = r.irq_oe;
    assign irq_flags_clear = r.flags_clear;
    assign analog_powered_down = r.analog_off;
    assign audio_detect_en = r.detect_en;
    assign two_channel_processing = r.two_ch;
    assign decimator_response_sel = r.proc_ctrl[`PROC_FLT_BIT];
    assign highpass_on = r.proc_ctrl[`PROC_HPF_BIT];
    assign silence_second_right = r.proc_ctrl[`PROC_MUTE_C2R];
    assign silence_second_left = r.proc_ctrl[`PROC_MUTE_C2L];
    assign silence_first_right = r.proc_ctrl[`PROC_MUTE_C1R];
    assign silence_first_left = r.proc_ctrl[`PROC_MUTE_C1L];
    assign power_state = r.psm;
    assign detected_rate_class = r.rate;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_open_drain;
        ($past(sense) == `SENSE_OPEN_DRAIN) |-> (irq_oe == r.irq_active) && !irq_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin wrong");

    property p_pulse_load;
        irq_event && (width != `WIDTH_LEVEL) |=> r.irq_active && (r.irq_cnt ==
            20'(IRQ_UNIT_CYCLES * (int'($past(width)) + 1) - 1));
    endproperty
    a_pulse_load: assert property (p_pulse_load) else $error("pulse length wrong");

    property p_pulse_end;
        r.irq_active && (r.irq_cnt == 20'h00000) && (width != `WIDTH_LEVEL) && !irq_event
            |=> !r.irq_active;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");

    property p_level_hold;
        r.irq_active && (width == `WIDTH_LEVEL) && !irq_event && !ack_write |=> r.irq_active;
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level interrupt dropped");

    property p_powerdown;
        (r.psm == adc_ctrl_pkg::PS_STANDBY) && r.pwr_req[`PWR_ANALOG_BIT]
            |=> ##1 analog_powered_down;
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("no analog power-down");

    property p_sleep;
        (r.psm == adc_ctrl_pkg::PS_STANDBY) && r.pwr_req[`PWR_SLEEP_BIT]
            && !r.pwr_req[`PWR_ANALOG_BIT] |=> audio_detect_en && (power_state == 4'h9);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");

    property p_standby;
        (r.psm == adc_ctrl_pkg::PS_RUN) && r.pwr_req[`PWR_HOLD_BIT]
            |=> (power_state == 4'h5) ##[1:300] (power_state == 4'h3);
    endproperty
    a_standby: assert property (p_standby) else $error("run not left via fade-out");

    property p_run_entry;
        $rose(r.psm == adc_ctrl_pkg::PS_RUN) |-> ($past(r.psm) == adc_ctrl_pkg::PS_FADE_IN);
    endproperty
    a_run_entry: assert property (p_run_entry) else $error("run without fade-in");

    property p_two_ch_stable;
        (r.psm == adc_ctrl_pkg::PS_RUN) |-> $stable(two_channel_processing);
    endproperty
    a_two_ch_stable: assert property (p_two_ch_stable) else $error("mode changed in run");

    property p_mute_write;
        reg_wr && (reg_addr == `REG_PROC_CTRL) |=> (silence_first_left == $past(reg_wdata[0]))
            && (decimator_response_sel == $past(reg_wdata[5]));
    endproperty
    a_mute_write: assert property (p_mute_write) else $error("processing write lost");

    property p_rate;
        ##1 (detected_rate_class == $past(rate_class_in));
    endproperty
    a_rate: assert property (p_rate) else $error("rate class not tracked");

    property p_ack;
        // Back-to-back acknowledges are legal, so the second cycle follows the strobe
        ack_write |=> irq_flags_clear ##1 (irq_flags_clear == $past(ack_write));
    endproperty
    a_ack: assert property (p_ack) else $error("flag clear pulse wrong");

    c_run: cover property ((r.psm == adc_ctrl_pkg::PS_FADE_IN) ##[1:300]
        (r.psm == adc_ctrl_pkg::PS_RUN));
    c_sleep: cover property (audio_detect_en);
    c_level_ack: cover property (r.irq_active && (width == `WIDTH_LEVEL) ##1 ack_write);
endmodule : adc_power_state_irq_ctrl

`default_nettype wire

// >>> adc_power_state_irq_ctrl_bench.sv
// Self-checking testbench of the power-state, interrupt pin and register block
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_params.svh"

module adc_power_state_irq_ctrl_bench;
    // Short interrupt unit keeps the pulse sweeps within a few hundred cycles
    localparam int UNIT = 10;
    localparam int FADE = 4;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic irq_event = 1'b0;
    logic clk_stable = 1'b0;
    logic [2:0] rate_class_in = 3'h0;
    logic [7:0] reg_rdata;
    logic irq_out, irq_oe, irq_flags_clear, analog_powered_down, audio_detect_en;
    logic two_ch, dec_sel, hp_on, s2r, s2l, s1r, s1l;
    logic [3:0] power_state;
    logic [2:0] rate_cls;
    int n_mismatch = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;

    adc_power_state_irq_ctrl #(.IRQ_UNIT_CYCLES(UNIT), .FADE_CYCLES(FADE)) dut (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_event(irq_event),
        .clk_stable(clk_stable), .rate_class_in(rate_class_in), .irq_out(irq_out),
        .irq_oe(irq_oe), .irq_flags_clear(irq_flags_clear),
        .analog_powered_down(analog_powered_down), .audio_detect_en(audio_detect_en),
        .two_channel_processing(two_ch), .decimator_response_sel(dec_sel),
        .highpass_on(hp_on), .silence_second_right(s2r), .silence_second_left(s2l),
        .silence_first_right(s1r), .silence_first_left(s1l), .power_state(power_state),
        .detected_rate_class(rate_cls)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        tick(1);
        chk($sformatf("read %h", a), exp, reg_rdata);
    endtask : rdchk

    // Waits for a state code and notes whether an intermediate code was shown
    task automatic wait_ps(input logic [3:0] code, input logic [3:0] via);
        bit seen;
        int i;
        seen = (power_state === via);
        for (i = 0; i < 200 && power_state !== code; i++) begin
            tick(1);
            if (power_state === via) seen = 1'b1;
        end
        chk("power state", {4'h0, code}, {4'h0, power_state});
        chk("intermediate state seen", 8'h01, {7'h0, seen});
    endtask : wait_ps

    task automatic test_reset;
        rdchk(`REG_IRQ_CFG, 8'h10);
        rdchk(`REG_PWR_REQ, 8'h70);
        rdchk(`REG_PROC_CTRL, 8'h10);
        rdchk(8'h55, 8'h00);
        chk("state waiting clock", 8'h01, {4'h0, power_state});
        chk("analog up", 8'h00, {7'h0, analog_powered_down});
        $display("test_reset done");
    endtask : test_reset

    task automatic test_proc;
        int i;
        for (i = 0; i < 6; i++) begin
            wr(`REG_PROC_CTRL, 8'h01 << i);
            tick(1);
            chk("proc outputs", 8'h01 << i, {2'b00, dec_sel, hp_on, s2r, s2l, s1r, s1l});
            rdchk(`REG_PROC_CTRL, 8'h01 << i);
        end
        wr(`REG_PROC_CTRL, 8'h10);
        $display("test_proc done");
    endtask : test_proc

    task automatic test_psm;
        @(posedge clk);
        clk_stable <= 1'b1;
        wait_ps(4'hf, 4'h4);
        wr(`REG_PWR_STAT, 8'h00);
        rdchk(`REG_PWR_STAT, 8'h0f);
        wr(`REG_PWR_REQ, 8'h71);
        wait_ps(4'h3, 4'h5);
        // Channel count is only changed outside run
        wr(`REG_PROC_CTRL, 8'h90);
        tick(1);
        chk("two channel", 8'h01, {7'h0, two_ch});
        wr(`REG_PWR_REQ, 8'h72);
        wait_ps(4'h9, 4'h3);
        chk("detect on", 8'h01, {7'h0, audio_detect_en});
        wr(`REG_PWR_REQ, 8'h74);
        wait_ps(4'h0, 4'h3);
        chk("analog down", 8'h01, {7'h0, analog_powered_down});
        wr(`REG_PWR_REQ, 8'h70);
        wait_ps(4'hf, 4'h4);
        rdchk(`REG_PWR_REQ, 8'h70);
        $display("test_psm done");
    endtask : test_psm

    task automatic test_rate;
        int i;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            rate_class_in <= i[2:0];
            tick(2);
            chk("rate class", i[7:0], {5'h0, rate_cls});
            rdchk(`REG_RATE_CLASS, i[7:0]);
        end
        wr(`REG_RATE_CLASS, 8'h00);
        rdchk(`REG_RATE_CLASS, 8'h07);
        $display("test_rate done");
    endtask : test_rate

    task automatic irq_run(input logic [1:0] sense, input logic [1:0] width);
        int n;
        wr(`REG_IRQ_CFG, {2'b00, sense, 2'b00, width});
        tick(1);
        chk("idle out", {7'h0, sense == 2'h0}, {7'h0, irq_out});
        chk("idle oe", {7'h0, sense != 2'h2}, {7'h0, irq_oe});
        @(posedge clk);
        irq_event <= 1'b1;
        @(posedge clk);
        irq_event <= 1'b0;
        #1;
        n = 0;
        // Reserved sense code drives like active high
        while (n < 1000 && irq_oe === 1'b1 && irq_out === (sense != 2'h0 && sense != 2'h2)) begin
            n++;
            tick(1);
        end
        chk("pulse cycles", 8'(UNIT * (width + 1)), n[7:0]);
        chk("after out", {7'h0, sense == 2'h0}, {7'h0, irq_out});
    endtask : irq_run

    task automatic test_irq;
        int s, w;
        for (s = 0; s < 4; s++) begin
            for (w = 0; w < 3; w++) irq_run(s[1:0], w[1:0]);
        end
        $display("test_irq done");
    endtask : test_irq

    task automatic test_level;
        wr(`REG_IRQ_CFG, 8'h13);
        @(posedge clk);
        irq_event <= 1'b1;
        @(posedge clk);
        irq_event <= 1'b0;
        tick(UNIT * 4 + 5);
        chk("level held", 8'h01, {7'h0, irq_out});
        // A nonzero write to the enable register is no acknowledge
        wr(`REG_IRQ_ENABLE, 8'h01);
        #1;
        chk("no clear", 8'h00, {7'h0, irq_flags_clear});
        tick(1);
        chk("level kept", 8'h01, {7'h0, irq_out});
        wr(`REG_IRQ_ENABLE, 8'h00);
        #1;
        chk("clear pulse", 8'h01, {7'h0, irq_flags_clear});
        tick(1);
        chk("clear ends", 8'h00, {7'h0, irq_flags_clear});
        chk("level dropped", 8'h00, {7'h0, irq_out});
        $display("test_level done");
    endtask : test_level

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        tick(2);
        test_reset();
        test_proc();
        test_psm();
        test_rate();
        test_irq();
        test_level();
        final_report();
    end

    // The whole sequence needs about 500 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("[FAIL] watchdog expected finish seen hang");
        final_report();
    end
endmodule : adc_power_state_irq_ctrl_bench
`default_nettype wire
